// >>> rtl/rcps_pkg.sv
// Constants, register map and types for the reference clock and power-save block.
// Notes on behaviour
// - Enable bit 15 drives the divided reference clock onto the pin; clear disables.
// - Four-bit divisor code n divides the base clock by two to the n, except code 0 on the system clock, which divides by two.
// - Source bit 12 set picks primary oscillator, clear picks system clock.
// - Sleep-run bit 13 decides whether the reference output keeps running in Sleep.
// - Runs in Sleep only with sleep-run and source set; oscillator off unless enabled.
// - With source clear the output follows the system clock through switches.
// - Power-save operand zero enters Sleep, operand one enters Idle.
// - Sleep stops system clock, on-chip oscillator, code execution and clocked peripherals.
// - In Sleep low-power oscillator runs if watchdog enabled; clock monitor stops.
// - Watchdog, if enabled, is cleared on entry to Sleep and Idle.
// - Sleep ends on enabled interrupt, any reset or watchdog time-out.
// - Idle stops execution, keeps system clock; low-power oscillator kept for watchdog/monitor.
// - Idle wake restores CPU clock at once on interrupt, reset or watchdog time-out.
// - Interrupt during power-save instruction is held until entry completes, then wakes.
// - Regulator off in Sleep when its bit is clear, adding about 190 us wake-up.
// - Doze enable bit 11 slows CPU clock against peripheral clock while executing.
// - Doze ratio bits 14 to 12 select 1:1 up to 1:128, default 1:1.
// - Doze keeps system clock and peripherals at full rate, CPU enable stays synchronous.
// - Return-on-interrupt set makes an interrupt restore full speed; clear leaves Doze alone.
// - Doze enable clears itself when return-on-interrupt is set and an interrupt occurs.
// - Doze code n gives ratio one to two to the n.
package rcps_pkg;
   localparam logic [3:0]  ADR_REFOCTL   = 4'h0;
   localparam logic [3:0]  ADR_CLOCK_DIVIDER_REGISTER    = 4'h4;
   localparam logic [3:0]  ADR_PWRCTL    = 4'h8;
   localparam logic [3:0]  ADR_STATUS    = 4'hc;
   localparam logic [15:0] REFOCTL_RST   = 16'h0000;
   localparam logic [15:0] CLOCK_DIVIDER_REGISTER_RST    = 16'h0000;
   localparam logic [15:0] PWRCTL_RST    = 16'h0000;
   localparam logic [15:0] REFOCTL_MASK  = 16'hbf00;
   localparam logic [15:0] CLOCK_DIVIDER_REGISTER_MASK   = 16'hf800;
   localparam logic [15:0] PWRCTL_MASK   = 16'h0107;
   localparam int          RO_EN         = 15;
   localparam int          RO_SLP        = 13;
   localparam int          RO_SEL        = 12;
   localparam int          RO_DIV_LSB    = 8;
   localparam int          CD_ROI        = 15;
   localparam int          CD_DOZE_LSB   = 12;
   localparam int          CD_DOZE_ENABLE      = 11;
   localparam int          PC_REGSLP     = 8;
   localparam int          PC_PRIMARY_OSC_SLEEP_ENABLE     = 2;
   localparam int          PC_WDTEN      = 1;
   localparam int          PC_FSCMEN     = 0;
   localparam int          ST_DOZE       = 3;
   localparam int          ST_WAKEWAIT   = 4;
   localparam logic        OP_SLEEP      = 1'b0;
   localparam logic        OP_IDLE       = 1'b1;
   localparam int          CLK_MHZ       = 125;
   localparam int          REG_WAKE_NS   = 190000;
   localparam int          REG_WAKE_CYC  = (REG_WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int          DIV_W         = 4;
   localparam int          DOZE_W        = 3;
   localparam int          DIVCNT_W      = 15;
   localparam int          DOZECNT_W     = 7;

   typedef enum logic [2:0] {
      PM_RUN,
      PM_ENTER_IDLE,
      PM_ENTER_SLEEP,
      PM_IDLE,
      PM_SLEEP,
      PM_WAKEWAIT
   } rcps_pm_t;
endpackage

// >>> rtl/rcps_top.sv
// Reference clock output, power-save sequencing and doze, with a Wishbone register slave.
`timescale 1ns/1ps
module rcps_top #(
   parameter int P_REG_WAKE_CYCLES = rcps_pkg::REG_WAKE_CYC  // Regulator wake delay, cycles
) (
   input  wire logic        i_clk,             // System clock, 125 MHz
   input  wire logic        i_reset,           // Asynchronous reset, active high
   input  wire logic        i_ce,              // Clock enable, freezes all state when low
   input  wire logic        i_wb_cyc,          // Wishbone cycle
   input  wire logic        i_wb_stb,          // Wishbone strobe
   input  wire logic        i_wb_we,           // Wishbone write
   input  wire logic [3:0]  i_wb_adr,          // Wishbone byte address
   input  wire logic [3:0]  i_wb_sel,          // Wishbone byte lanes
   input  wire logic [31:0] i_wb_dat,          // Wishbone write data
   output logic      [31:0] o_wb_dat,          // Wishbone read data
   output logic             o_wb_ack,          // Wishbone acknowledge
   input  wire logic        i_posc_clk,        // Primary oscillator level, sampled
   input  wire logic        i_power_save_instruction_valid,    // Power-save instruction executes
   input  wire logic        i_power_save_instruction_operand,  // 0 Sleep, 1 Idle
   input  wire logic        i_irq,             // Enabled interrupt pending
   input  wire logic        i_wdt_timeout,     // Watchdog time-out
   output logic             o_refout_pin,      // Reference clock output
   output logic             o_cpu_halt,        // CPU stopped
   output logic             o_cpu_clk_en,      // CPU clock enable, doze gating
   output logic             o_sysclk_stop,     // System clock source stopped
   output logic             o_periph_stop,     // Clocked peripherals stopped
   output logic             o_wdt_clear,       // Watchdog clear pulse
   output logic             o_lpoc_run,        // Low-power oscillator runs
   output logic             o_fail_safe_clock_monitor_active,     // Clock monitor operates
   output logic             o_posc_off,        // Primary oscillator powered down
   output logic             o_regulator_off,   // Regulator disabled
   output logic             o_wake             // Wake pulse, CPU resumes
);
   localparam int WW = $clog2(P_REG_WAKE_CYCLES + 1);

   if (P_REG_WAKE_CYCLES < 1) begin : g_bad_wake
      $error("P_REG_WAKE_CYCLES must be at least one");
   end

   typedef struct packed {
      logic [15:0]                       refctl;
      logic [15:0]                       clock_divider_register;
      logic [15:0]                       pwrctl;
      rcps_pkg::rcps_pm_t                pm;
      logic [WW-1:0]                     wake_cnt;
      logic [rcps_pkg::DOZECNT_W-1:0]    doze_cnt;
      logic                              posc_d;
      logic [rcps_pkg::DIV_W-1:0]        act_div;
      logic                              act_src;
      logic [rcps_pkg::DIVCNT_W-1:0]     div_cnt;
      logic                              ref_out;
      logic                              wb_ack;
      logic [31:0]                       wb_dat;
      logic                              cpu_halt;
      logic                              cpu_clk_en;
      logic                              sysclk_stop;
      logic                              periph_stop;
      logic                              wdt_clear;
      logic                              lpoc_run;
      logic                              fail_safe_clock_monitor_active;
      logic                              posc_off;
      logic                              reg_off;
      logic                              wake;
   } rcps_state_t;

   rcps_state_t st_ff;
   rcps_state_t nxt_st;

   function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] sel, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (sel[0]) begin
         v[7:0] = d[7:0];
      end
      if (sel[1]) begin
         v[15:8] = d[15:8];
      end
      return v & mask;
   endfunction

   logic                          acc;
   logic                          posc_rise;
   logic                          posc_fall;
   logic                          in_sleep;
   logic                          ref_run;
   logic                          base_tick;
   logic                          period_end;
   logic [rcps_pkg::DIVCNT_W-1:0] half_lim;
   logic [rcps_pkg::DOZECNT_W-1:0] doze_lim;
   logic                          doze_on;
   logic                          wake_evt;
   logic [31:0]                   rd;

   always_comb begin
      nxt_st = st_ff;
      acc       = i_wb_cyc & i_wb_stb & ~st_ff.wb_ack;
      posc_rise = i_posc_clk & ~st_ff.posc_d;
      posc_fall = ~i_posc_clk & st_ff.posc_d;
      in_sleep  = (st_ff.pm == rcps_pkg::PM_SLEEP) || (st_ff.pm == rcps_pkg::PM_WAKEWAIT);
      wake_evt  = i_irq | i_wdt_timeout;
      doze_on   = st_ff.clock_divider_register[rcps_pkg::CD_DOZE_ENABLE];
      half_lim  = '0;
      doze_lim  = '0;
      rd        = '0;

      // Register bus: one-cycle registered ack, unmapped reads zero, writes dropped
      nxt_st.wb_ack = acc;
      case (i_wb_adr)
         rcps_pkg::ADR_REFOCTL: rd[15:0] = st_ff.refctl;
         rcps_pkg::ADR_CLOCK_DIVIDER_REGISTER:  rd[15:0] = st_ff.clock_divider_register;
         rcps_pkg::ADR_PWRCTL:  rd[15:0] = st_ff.pwrctl;
         rcps_pkg::ADR_STATUS: begin
            rd[2:0]                    = st_ff.pm;
            rd[rcps_pkg::ST_DOZE]      = doze_on;
            rd[rcps_pkg::ST_WAKEWAIT]  = st_ff.pm == rcps_pkg::PM_WAKEWAIT;
         end
         default: rd = '0;
      endcase
      nxt_st.wb_dat = (acc && !i_wb_we) ? rd : '0;
      if (acc && i_wb_we) begin
         case (i_wb_adr)
            rcps_pkg::ADR_REFOCTL: nxt_st.refctl = lane_write(st_ff.refctl, i_wb_dat,
                                      i_wb_sel, rcps_pkg::REFOCTL_MASK);
            rcps_pkg::ADR_CLOCK_DIVIDER_REGISTER:  nxt_st.clock_divider_register = lane_write(st_ff.clock_divider_register, i_wb_dat,
                                      i_wb_sel, rcps_pkg::CLOCK_DIVIDER_REGISTER_MASK);
            rcps_pkg::ADR_PWRCTL:  nxt_st.pwrctl = lane_write(st_ff.pwrctl, i_wb_dat,
                                      i_wb_sel, rcps_pkg::PWRCTL_MASK);
            default: nxt_st.pwrctl = st_ff.pwrctl;
         endcase
      end
      // Hardware clear beats a simultaneous software write of the doze bit
      if (i_irq && st_ff.clock_divider_register[rcps_pkg::CD_ROI] && doze_on) begin
         nxt_st.clock_divider_register[rcps_pkg::CD_DOZE_ENABLE] = 1'b0;
      end

      // Power-save sequencing
      nxt_st.wdt_clear = 1'b0;
      nxt_st.wake      = 1'b0;
      case (st_ff.pm)
         rcps_pkg::PM_RUN: begin
            if (i_power_save_instruction_valid) begin
               nxt_st.pm = (i_power_save_instruction_operand == rcps_pkg::OP_IDLE) ?
                           rcps_pkg::PM_ENTER_IDLE : rcps_pkg::PM_ENTER_SLEEP;
               nxt_st.wdt_clear = st_ff.pwrctl[rcps_pkg::PC_WDTEN];
            end
         end
         // Entry takes one cycle; a pending interrupt waits it out
         rcps_pkg::PM_ENTER_IDLE:  nxt_st.pm = rcps_pkg::PM_IDLE;
         rcps_pkg::PM_ENTER_SLEEP: nxt_st.pm = rcps_pkg::PM_SLEEP;
         rcps_pkg::PM_IDLE: begin
            if (wake_evt) begin
               nxt_st.pm   = rcps_pkg::PM_RUN;
               nxt_st.wake = 1'b1;
            end
         end
         rcps_pkg::PM_SLEEP: begin
            if (wake_evt) begin
               if (st_ff.pwrctl[rcps_pkg::PC_REGSLP]) begin
                  nxt_st.pm   = rcps_pkg::PM_RUN;
                  nxt_st.wake = 1'b1;
               end else begin
                  nxt_st.pm       = rcps_pkg::PM_WAKEWAIT;
                  nxt_st.wake_cnt = WW'(P_REG_WAKE_CYCLES - 1);
               end
            end
         end
         rcps_pkg::PM_WAKEWAIT: begin
            if (st_ff.wake_cnt == '0) begin
               nxt_st.pm   = rcps_pkg::PM_RUN;
               nxt_st.wake = 1'b1;
            end else begin
               nxt_st.wake_cnt = st_ff.wake_cnt - 1'b1;
            end
         end
         default: nxt_st.pm = rcps_pkg::PM_RUN;
      endcase

      // Status outputs follow the next mode so they leave flops in step with it
      nxt_st.cpu_halt    = nxt_st.pm != rcps_pkg::PM_RUN;
      nxt_st.sysclk_stop = (nxt_st.pm == rcps_pkg::PM_SLEEP) ||
                           (nxt_st.pm == rcps_pkg::PM_WAKEWAIT);
      nxt_st.periph_stop = nxt_st.sysclk_stop;
      nxt_st.fail_safe_clock_monitor_active = st_ff.pwrctl[rcps_pkg::PC_FSCMEN] & ~nxt_st.sysclk_stop;
      nxt_st.lpoc_run    = st_ff.pwrctl[rcps_pkg::PC_WDTEN] | nxt_st.fail_safe_clock_monitor_active;
      nxt_st.posc_off    = nxt_st.sysclk_stop & ~st_ff.pwrctl[rcps_pkg::PC_PRIMARY_OSC_SLEEP_ENABLE];
      nxt_st.reg_off     = (nxt_st.pm == rcps_pkg::PM_SLEEP) &
                           ~st_ff.pwrctl[rcps_pkg::PC_REGSLP];

      // Doze: one CPU enable per 2^n system cycles, peripherals untouched
      doze_lim = rcps_pkg::DOZECNT_W'((8'h01 << st_ff.clock_divider_register[rcps_pkg::CD_DOZE_LSB +:
                                        rcps_pkg::DOZE_W]) - 8'h01);
      if (nxt_st.cpu_halt) begin
         nxt_st.cpu_clk_en = 1'b0;
         nxt_st.doze_cnt   = '0;
      end else if (nxt_st.clock_divider_register[rcps_pkg::CD_DOZE_ENABLE]) begin
         nxt_st.cpu_clk_en = st_ff.doze_cnt == '0;
         nxt_st.doze_cnt   = (st_ff.doze_cnt >= doze_lim) ? '0 : st_ff.doze_cnt + 1'b1;
      end else begin
         nxt_st.cpu_clk_en = 1'b1;
         nxt_st.doze_cnt   = '0;
      end

      // Reference output: system source stops with the system clock in Sleep
      nxt_st.posc_d = i_posc_clk;
      ref_run = st_ff.refctl[rcps_pkg::RO_EN] &&
                (!in_sleep || (st_ff.refctl[rcps_pkg::RO_SLP] &&
                 st_ff.refctl[rcps_pkg::RO_SEL] &&
                 st_ff.pwrctl[rcps_pkg::PC_PRIMARY_OSC_SLEEP_ENABLE]));
      base_tick = st_ff.act_src ? posc_rise : 1'b1;
      half_lim  = rcps_pkg::DIVCNT_W'(((16'h0001 << st_ff.act_div) >> 1) - 16'h0001);
      if (st_ff.act_div == '0) begin
         // Pass-through: crystal level copied; system clock can only toggle per cycle
         period_end = st_ff.act_src ? posc_fall : st_ff.ref_out;
      end else begin
         period_end = base_tick && st_ff.ref_out && (st_ff.div_cnt == half_lim);
      end
      if (!ref_run) begin
         nxt_st.ref_out = 1'b0;
         nxt_st.div_cnt = '0;
         nxt_st.act_div = st_ff.refctl[rcps_pkg::RO_DIV_LSB +: rcps_pkg::DIV_W];
         nxt_st.act_src = st_ff.refctl[rcps_pkg::RO_SEL];
      end else begin
         if (st_ff.act_div == '0) begin
            nxt_st.ref_out = st_ff.act_src ? i_posc_clk : ~st_ff.ref_out;
         end else if (base_tick) begin
            if (st_ff.div_cnt == half_lim) begin
               nxt_st.div_cnt = '0;
               nxt_st.ref_out = ~st_ff.ref_out;
            end else begin
               nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
            end
         end
         // New settings only at a falling edge, so no runt pulse
         if (period_end) begin
            nxt_st.act_div = st_ff.refctl[rcps_pkg::RO_DIV_LSB +: rcps_pkg::DIV_W];
            nxt_st.act_src = st_ff.refctl[rcps_pkg::RO_SEL];
            nxt_st.div_cnt = '0;
            nxt_st.ref_out = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_ff             <= '0;
         st_ff.refctl      <= rcps_pkg::REFOCTL_RST;
         st_ff.clock_divider_register      <= rcps_pkg::CLOCK_DIVIDER_REGISTER_RST;
         st_ff.pwrctl      <= rcps_pkg::PWRCTL_RST;
         st_ff.pm          <= rcps_pkg::PM_RUN;
         st_ff.cpu_clk_en  <= 1'b1;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   assign o_wb_dat        = st_ff.wb_dat;
   assign o_wb_ack        = st_ff.wb_ack;
   assign o_refout_pin    = st_ff.ref_out;
   assign o_cpu_halt      = st_ff.cpu_halt;
   assign o_cpu_clk_en    = st_ff.cpu_clk_en;
   assign o_sysclk_stop   = st_ff.sysclk_stop;
   assign o_periph_stop   = st_ff.periph_stop;
   assign o_wdt_clear     = st_ff.wdt_clear;
   assign o_lpoc_run      = st_ff.lpoc_run;
   assign o_fail_safe_clock_monitor_active   = st_ff.fail_safe_clock_monitor_active;
   assign o_posc_off      = st_ff.posc_off;
   assign o_regulator_off = st_ff.reg_off;
   assign o_wake          = st_ff.wake;
endmodule

// >>> bench/rcps_props.sv
// Port-level assertions for the reference clock and power-save block.
`timescale 1ns/1ps
module rcps_props (
   input wire logic i_clk,            // System clock
   input wire logic i_reset,          // Async reset, active high
   input wire logic i_ce,             // Clock enable
   input wire logic i_power_save_instruction_valid,   // Power-save request
   input wire logic i_power_save_instruction_operand, // 0 Sleep, 1 Idle
   input wire logic i_irq,            // Enabled interrupt
   input wire logic i_wdt_timeout,    // Watchdog time-out
   input wire logic o_cpu_halt,       // CPU stopped
   input wire logic o_cpu_clk_en,     // CPU clock enable
   input wire logic o_sysclk_stop,    // System clock stopped
   input wire logic o_periph_stop,    // Peripherals stopped
   input wire logic o_wdt_clear,      // Watchdog clear pulse
   input wire logic o_fail_safe_clock_monitor_active,    // Clock monitor on
   input wire logic o_regulator_off,  // Regulator off
   input wire logic o_wake            // Wake pulse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   save_halts_a:
   assert property (i_ce && i_power_save_instruction_valid && !o_cpu_halt |=> o_cpu_halt && !o_cpu_clk_en)
      else $error("power-save request did not halt the CPU");
   save_mode_a:
   assert property (i_ce && i_power_save_instruction_valid && !o_cpu_halt
                    |-> ##2 (o_sysclk_stop != $past(i_power_save_instruction_operand, 2)))
      else $error("operand did not pick Sleep or Idle");
   sleep_stops_a:
   assert property (o_sysclk_stop |-> o_cpu_halt && o_periph_stop && !o_cpu_clk_en)
      else $error("Sleep left CPU or peripherals running");
   sleep_monitor_a:
   assert property (o_regulator_off |-> o_sysclk_stop && !o_fail_safe_clock_monitor_active)
      else $error("monitor or regulator wrong in Sleep");
   wdt_clear_cause_a:
   assert property (o_wdt_clear |-> $past(i_power_save_instruction_valid) && o_cpu_halt ##1 !o_wdt_clear)
      else $error("watchdog clear without power-save entry");
   enter_holds_a:
   assert property ($rose(o_cpu_halt) |=> o_cpu_halt)
      else $error("woke before entry completed");
   idle_wake_a:
   assert property (o_cpu_halt && $past(o_cpu_halt) && !o_sysclk_stop
                    && (i_irq || i_wdt_timeout) |=> o_wake && !o_cpu_halt)
      else $error("Idle did not wake in one cycle");
   wake_pulse_a:
   assert property (o_wake |-> $fell(o_cpu_halt) ##1 !o_wake)
      else $error("wake pulse not tied to halt release");
endmodule

bind rcps_top rcps_props rcps_props_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
   .i_power_save_instruction_valid(i_power_save_instruction_valid), .i_power_save_instruction_operand(i_power_save_instruction_operand), .i_irq(i_irq),
   .i_wdt_timeout(i_wdt_timeout), .o_cpu_halt(o_cpu_halt), .o_cpu_clk_en(o_cpu_clk_en),
   .o_sysclk_stop(o_sysclk_stop), .o_periph_stop(o_periph_stop), .o_wdt_clear(o_wdt_clear),
   .o_fail_safe_clock_monitor_active(o_fail_safe_clock_monitor_active), .o_regulator_off(o_regulator_off), .o_wake(o_wake));

// >>> bench/rcps_core_model.sv
// Model of the processor core and the crystal that face the block.
`timescale 1ns/1ps
module rcps_core_model (
   input  wire logic i_clk,   // System clock
   output logic      o_posc,  // Crystal level
   output logic      o_valid, // Power-save instruction
   output logic      o_op,    // Operand
   output logic      o_irq,   // Interrupt
   output logic      o_wdt    // Watchdog time-out
);
   logic [1:0] div_ff;
   initial begin
      {o_posc, o_valid, o_op, o_irq, o_wdt} = 5'h00;
      div_ff = 2'h0;
   end
   // Crystal runs free, six system clocks a period
   always @(posedge i_clk) begin
      div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      if (div_ff == 2'h2) o_posc <= ~o_posc;
   end
   // Optional interrupt lands during entry and stays pending until the mode is reached
   task automatic save(input logic op, input logic irq_too);
      @(posedge i_clk) {o_valid, o_op} <= {1'b1, op};
      @(posedge i_clk) {o_valid, o_op, o_irq} <= {1'b0, ~op, irq_too};
      @(posedge i_clk);
      @(posedge i_clk) o_irq <= 1'b0;
   endtask
   task automatic pulse(input logic wdt);
      @(posedge i_clk) {o_wdt, o_irq} <= {wdt, ~wdt};
      @(posedge i_clk) {o_wdt, o_irq} <= 2'h0;
   endtask
endmodule

// >>> bench/testbench.sv
// Register, reference clock, doze and power-save tests for the block.
`timescale 1ns/1ps
module testbench;
   logic        clk, rst, ce, cyc, stb, we, pin, halt, cen, sstop, lpoc, wclr, wake, roff;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat;
   logic        ack, posc, pv, pop, irq, wdt, pstop, poff;
   logic [15:0] q;
   int          failures, checks_done, n, c;
   int          n_clr = 0;

   rcps_top #(.P_REG_WAKE_CYCLES(8)) rcps_top_i (.i_clk(clk), .i_reset(rst), .i_ce(ce),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_posc_clk(posc),
      .i_power_save_instruction_valid(pv), .i_power_save_instruction_operand(pop), .i_irq(irq), .i_wdt_timeout(wdt),
      .o_refout_pin(pin), .o_cpu_halt(halt), .o_cpu_clk_en(cen), .o_sysclk_stop(sstop),
      .o_periph_stop(pstop), .o_wdt_clear(wclr), .o_lpoc_run(lpoc), .o_fail_safe_clock_monitor_active(),
      .o_posc_off(poff), .o_regulator_off(roff), .o_wake(wake));
   rcps_core_model rcps_core_model_i (.i_clk(clk), .o_posc(posc), .o_valid(pv), .o_op(pop),
      .o_irq(irq), .o_wdt(wdt));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (wclr === 1'b1) n_clr <= n_clr + 1;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
      int t;
      t = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 16'h0000, d};
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      q = rdat[15:0];
      {cyc, stb} <= 2'h0;
      if (t >= 20) failures++;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000);
      chk("register", {12'h000, a, e}, {12'h000, a, q});
   endtask
   // Counts CPU enables or pin rising edges over w cycles
   task automatic cnt(input logic en, input int w, output int k);
      logic p;
      k = 0;
      p = pin;
      repeat (w) begin
         @(posedge clk);
         k += en ? int'(cen === 1'b1) : int'(pin === 1'b1 && p === 1'b0);
         p = pin;
      end
   endtask
   task automatic wait_wake(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wake !== 1'b1 && k < 100);
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      {rst, ce, cyc, stb, we, adr, sel, wdat} = {4'hc, 1'b0, 4'h0, 4'h3, 32'h0};
      {failures, checks_done} = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      cnt(1'b0, 96, n);
      chk("pin_disabled", 0, n);
      rd(4'h0, 16'h0000);
      rd(4'h4, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'hbf00);
      wr(4'h0, 16'h0000);
      sel <= 4'h1;
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h0000);
      sel <= 4'h3;
      wr(4'hc, 16'hffff);
      rd(4'hc, 16'h0000);
      rd(4'h2, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         c = (i < 3) ? i + 1 : i - 3;
         wr(4'h0, 16'h8000 | ((i >= 3) ? 16'h1000 : 16'h0000) | 16'(c << 8));
         repeat (60) @(posedge clk);
         cnt(1'b0, 96, n);
         chk("refout_edges", 96 / ((i < 3) ? (1 << c) : (6 << c)), n);
      end
      ce <= 1'b0;
      @(posedge clk);
      cnt(1'b0, 48, n);
      ce <= 1'b1;
      chk("ce_freezes_pin", 0, n);
      wr(4'h4, 16'h7000);
      cnt(1'b1, 32, n);
      chk("no_doze_cpu_en", 32, n);
      for (int r = 0; r < 8; r++) begin
         wr(4'h4, 16'h0800 | 16'(r << 12));
         repeat (130) @(posedge clk);
         cnt(1'b1, 128, n);
         chk("doze_cpu_en", 128 >> r, n);
      end
      wr(4'h4, 16'hb800);
      rcps_core_model_i.pulse(1'b0);
      rd(4'h4, 16'hb000);
      cnt(1'b1, 16, n);
      chk("roi_full_speed", 16, n);
      wr(4'h4, 16'h3800);
      rcps_core_model_i.pulse(1'b0);
      rd(4'h4, 16'h3800);
      wr(4'h4, 16'h0000);
      wr(4'h8, 16'h0006);
      wr(4'h0, 16'hb100);
      // New divisor is taken at the old period end, let it settle first
      repeat (30) @(posedge clk);
      rcps_core_model_i.save(1'b0, 1'b0);
      chk("sleep_outputs", 5'h1e, {sstop, pstop, roff, lpoc, poff});
      cnt(1'b0, 96, n);
      chk("refout_in_sleep", 8, n);
      rcps_core_model_i.pulse(1'b0);
      wait_wake(n);
      chk("regulator_wake_wait", 1, n > 6 && n < 20);
      wr(4'h8, 16'h0002);
      wr(4'h0, 16'h9100);
      rcps_core_model_i.save(1'b0, 1'b0);
      chk("posc_off_in_sleep", 1, poff);
      cnt(1'b0, 96, n);
      chk("refout_stops_in_sleep", 0, n);
      rcps_core_model_i.pulse(1'b1);
      wait_wake(n);
      chk("wdt_wake", 1, n < 20);
      wr(4'h8, 16'h0102);
      rcps_core_model_i.save(1'b1, 1'b0);
      chk("idle_clock_runs", 3'h5, {halt, sstop, lpoc});
      rcps_core_model_i.pulse(1'b0);
      wait_wake(n);
      chk("idle_wake_fast", 1, n <= 2);
      rcps_core_model_i.save(1'b1, 1'b1);
      wait_wake(n);
      chk("held_irq_wakes", 1, n < 5 && halt === 1'b0);
      chk("wdt_clears", 4, n_clr);
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out;
   end
endmodule
